// file: rtl/eepg_cfg.svh
// timing, guard sequence and page layout constants for the eeprom host
// assumes a single 125 MHz system clock
`ifndef EEPG_CFG_SVH
`define EEPG_CFG_SVH

`define EEPG_CLK_MHZ     125
// least times round up, longest times round down
`define EEPG_CYC_MIN(ns) ((((ns) * `EEPG_CLK_MHZ) + 999) / 1000)
`define EEPG_CYC_MAX(ns) (((ns) * `EEPG_CLK_MHZ) / 1000)

`define EEPG_WP_NS       200
`define EEPG_WPH_NS      100
`define EEPG_ACC_NS      250
`define EEPG_DF_NS       60
`define EEPG_BLC_US      100
`define EEPG_WC_MS       10
`define EEPG_BLC_CYC     `EEPG_CYC_MAX(`EEPG_BLC_US * 1000)
`define EEPG_WC_CYC      `EEPG_CYC_MAX(`EEPG_WC_MS * 1000000)
`define EEPG_BLC_MARGIN  8
`define EEPG_SYNC_CYC    2

`define EEPG_PAGE_MSB    12
`define EEPG_PAGE_LSB    6
`define EEPG_PAGE_BYTES  7'h40
`define EEPG_GUARD_LEN   2'h3

`define EEPG_GRD_A0      13'h1555
`define EEPG_GRD_A1      13'h0AAA
`define EEPG_GRD_A2      13'h1555
`define EEPG_GRD_D0      8'hAA
`define EEPG_GRD_D1      8'h55
`define EEPG_GRD_D2      8'hA0

`endif

// file: rtl/eepg_pkg.sv
// types shared by the eeprom host files
// assumes eepg_cfg.svh for all numeric constants
package eepg_pkg;

    typedef enum logic [3:0] {
        EEPG_IDLE  = 4'b0000,
        EEPG_RD    = 4'b0001,
        EEPG_REC   = 4'b0010,
        EEPG_WAIT  = 4'b0011,
        EEPG_SET   = 4'b0100,
        EEPG_PULSE = 4'b0101,
        EEPG_HIGH  = 4'b0110,
        EEPG_PGAP  = 4'b0111,
        EEPG_PRD   = 4'b1000
    } eepg_state_t;

endpackage : eepg_pkg

// file: rtl/eepg_sync.sv
// two-flop synchroniser for the data pins
// assumes the bus is quiet while sampled, so skew between bits is harmless
`timescale 1ns/1ps

module eepg_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // pins and result
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule : eepg_sync

// file: rtl/eepg_host.sv
// host controller for a byte-wide parallel eeprom with guarded page write
// assumes the device pins connect directly; dq is split into in/out/enable
`timescale 1ns/1ps
`include "eepg_cfg.svh"

module eepg_host #(
    parameter int BLC_CYC = `EEPG_BLC_CYC,
    parameter int WC_CYC  = `EEPG_WC_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // command port
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [12:0] cmd_addr,
    input  wire logic [6:0]  cmd_len,
    // page byte port
    input  wire logic        wdat_valid,
    output logic             wdat_ready,
    input  wire logic [5:0]  wdat_offs,
    input  wire logic [7:0]  wdat_byte,
    // answers
    output logic             rd_valid,
    output logic      [7:0]  rd_data,
    output logic             wr_done,
    output logic             wr_err,
    output logic             busy,
    // device pins
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [12:0] addr,
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_in
);
    import eepg_pkg::*;

    localparam logic [15:0] WP_CYC  = 16'(`EEPG_CYC_MIN(`EEPG_WP_NS));
    localparam logic [15:0] WPH_CYC = 16'(`EEPG_CYC_MIN(`EEPG_WPH_NS));
    localparam logic [15:0] SMP_CYC =
        16'(`EEPG_CYC_MIN(`EEPG_ACC_NS) + `EEPG_SYNC_CYC);
    localparam logic [15:0] DF_CYC  = 16'(`EEPG_CYC_MIN(`EEPG_DF_NS));
    // leave room for the two cycles between accept and the strobe fall
    localparam logic [15:0] GAP_LIM = 16'(BLC_CYC - `EEPG_BLC_MARGIN);
    localparam logic [23:0] WC_LIM  = 24'(WC_CYC);

    function automatic logic [12:0] grd_addr(input logic [1:0] s);
        case (s)
            2'h0:    grd_addr = `EEPG_GRD_A0;
            2'h1:    grd_addr = `EEPG_GRD_A1;
            default: grd_addr = `EEPG_GRD_A2;
        endcase
    endfunction : grd_addr

    function automatic logic [7:0] grd_data(input logic [1:0] s);
        case (s)
            2'h0:    grd_data = `EEPG_GRD_D0;
            2'h1:    grd_data = `EEPG_GRD_D1;
            default: grd_data = `EEPG_GRD_D2;
        endcase
    endfunction : grd_data

    logic [7:0]  dq_s;
    eepg_sync #(.WIDTH(8)) eepg_sync_inst (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     (dq_in),
        .dout    (dq_s)
    );

    eepg_state_t st_r,      st_nxt;
    logic [15:0] tmr_r,     tmr_nxt;
    logic [15:0] gap_r,     gap_nxt;
    logic [23:0] poll_r,    poll_nxt;
    logic [1:0]  step_r,    step_nxt;
    logic [6:0]  len_r,     len_nxt;
    logic [6:0]  loaded_r,  loaded_nxt;
    logic [6:0]  page_r,    page_nxt;
    logic [12:0] last_a_r,  last_a_nxt;
    logic [7:0]  last_d_r,  last_d_nxt;
    logic        abort_r,   abort_nxt;
    logic        ce_n_r,    ce_n_nxt;
    logic        oe_n_r,    oe_n_nxt;
    logic        we_n_r,    we_n_nxt;
    logic [12:0] addr_r,    addr_nxt;
    logic [7:0]  dq_out_r,  dq_out_nxt;
    logic        dq_oe_r,   dq_oe_nxt;
    logic [7:0]  rd_data_r, rd_data_nxt;
    logic        rd_vld_r,  rd_vld_nxt;
    logic        done_r,    done_nxt;
    logic        err_r,     err_nxt;

    assign cmd_ready  = (st_r == EEPG_IDLE);
    assign wdat_ready = (st_r == EEPG_WAIT) && (gap_r < GAP_LIM);
    assign busy       = (st_r != EEPG_IDLE);
    assign ce_n       = ce_n_r;
    assign oe_n       = oe_n_r;
    assign we_n       = we_n_r;
    assign addr       = addr_r;
    assign dq_out     = dq_out_r;
    assign dq_oe      = dq_oe_r;
    assign rd_data    = rd_data_r;
    assign rd_valid   = rd_vld_r;
    assign wr_done    = done_r;
    assign wr_err     = err_r;

    always_comb begin
        st_nxt      = st_r;
        tmr_nxt     = tmr_r + 16'h0001;
        gap_nxt     = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
        poll_nxt    = poll_r;
        step_nxt    = step_r;
        len_nxt     = len_r;
        loaded_nxt  = loaded_r;
        page_nxt    = page_r;
        last_a_nxt  = last_a_r;
        last_d_nxt  = last_d_r;
        abort_nxt   = abort_r;
        ce_n_nxt    = ce_n_r;
        oe_n_nxt    = oe_n_r;
        we_n_nxt    = we_n_r;
        addr_nxt    = addr_r;
        dq_out_nxt  = dq_out_r;
        dq_oe_nxt   = dq_oe_r;
        rd_data_nxt = rd_data_r;
        rd_vld_nxt  = 1'b0;
        done_nxt    = 1'b0;
        err_nxt     = err_r;
        case (st_r)
            EEPG_IDLE: begin
                if (cmd_valid && cmd_write) begin
                    // every write starts from the guard bytes
                    page_nxt   = cmd_addr[`EEPG_PAGE_MSB:`EEPG_PAGE_LSB];
                    len_nxt    = (cmd_len == 7'h00) ? 7'h01 :
                                 (cmd_len > `EEPG_PAGE_BYTES) ?
                                 `EEPG_PAGE_BYTES : cmd_len;
                    step_nxt   = 2'h0;
                    loaded_nxt = 7'h00;
                    abort_nxt  = 1'b0;
                    addr_nxt   = grd_addr(2'h0);
                    dq_out_nxt = grd_data(2'h0);
                    dq_oe_nxt  = 1'b1;
                    st_nxt     = EEPG_SET;
                end else if (cmd_valid) begin
                    addr_nxt = cmd_addr;
                    ce_n_nxt = 1'b0;
                    oe_n_nxt = 1'b0;
                    tmr_nxt  = 16'h0000;
                    st_nxt   = EEPG_RD;
                end
            end
            EEPG_RD: begin
                if (tmr_r == SMP_CYC - 16'h0001) begin
                    rd_data_nxt = dq_s;
                    rd_vld_nxt  = 1'b1;
                    ce_n_nxt    = 1'b1;
                    tmr_nxt     = 16'h0000;
                    st_nxt      = EEPG_REC;
                end
            end
            EEPG_REC: begin
                // lets the device float its outputs before the next access
                if (tmr_r == DF_CYC - 16'h0001) begin
                    st_nxt = EEPG_IDLE;
                end
            end
            EEPG_WAIT: begin
                if (gap_r >= GAP_LIM) begin
                    // window gone: device is programming what it has
                    abort_nxt = 1'b1;
                    poll_nxt  = 24'h00_0000;
                    tmr_nxt   = 16'h0000;
                    st_nxt    = EEPG_PGAP;
                end else if (wdat_valid) begin
                    addr_nxt   = {page_r, wdat_offs};
                    dq_out_nxt = wdat_byte;
                    dq_oe_nxt  = 1'b1;
                    st_nxt     = EEPG_SET;
                end
            end
            EEPG_SET: begin
                // oe rises only together with both strobes low
                ce_n_nxt = 1'b0;
                we_n_nxt = 1'b0;
                oe_n_nxt = 1'b1;
                tmr_nxt  = 16'h0000;
                gap_nxt  = 16'h0000;
                st_nxt   = EEPG_PULSE;
            end
            EEPG_PULSE: begin
                if (tmr_r == WP_CYC - 16'h0001) begin
                    ce_n_nxt   = 1'b1;
                    we_n_nxt   = 1'b1;
                    oe_n_nxt   = 1'b0;
                    last_a_nxt = addr_r;
                    last_d_nxt = dq_out_r;
                    if (step_r == `EEPG_GUARD_LEN) begin
                        loaded_nxt = loaded_r + 7'h01;
                    end else begin
                        step_nxt = step_r + 2'h1;
                    end
                    tmr_nxt = 16'h0000;
                    st_nxt  = EEPG_HIGH;
                end
            end
            EEPG_HIGH: begin
                dq_oe_nxt = 1'b0;
                if (tmr_r == WPH_CYC - 16'h0001) begin
                    if (step_r != `EEPG_GUARD_LEN) begin
                        addr_nxt   = grd_addr(step_r);
                        dq_out_nxt = grd_data(step_r);
                        dq_oe_nxt  = 1'b1;
                        st_nxt     = EEPG_SET;
                    end else if (loaded_r == len_r) begin
                        poll_nxt = 24'h00_0000;
                        tmr_nxt  = 16'h0000;
                        st_nxt   = EEPG_PGAP;
                    end else begin
                        st_nxt = EEPG_WAIT;
                    end
                end
            end
            EEPG_PGAP: begin
                poll_nxt = poll_r + 24'h00_0001;
                if (tmr_r == DF_CYC - 16'h0001) begin
                    addr_nxt = last_a_r;
                    ce_n_nxt = 1'b0;
                    tmr_nxt  = 16'h0000;
                    st_nxt   = EEPG_PRD;
                end
            end
            EEPG_PRD: begin
                poll_nxt = poll_r + 24'h00_0001;
                if (tmr_r == SMP_CYC - 16'h0001) begin
                    ce_n_nxt = 1'b1;
                    tmr_nxt  = 16'h0000;
                    if (dq_s[7] == last_d_r[7]) begin
                        // true top bit means programming has ended
                        done_nxt = 1'b1;
                        err_nxt  = abort_r;
                        st_nxt   = EEPG_REC;
                    end else if (poll_r >= WC_LIM) begin
                        done_nxt = 1'b1;
                        err_nxt  = 1'b1;
                        st_nxt   = EEPG_REC;
                    end else begin
                        st_nxt = EEPG_PGAP;
                    end
                end
            end
            default: begin
                st_nxt = EEPG_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r      <= EEPG_IDLE;
            tmr_r     <= 16'h0000;
            gap_r     <= 16'h0000;
            poll_r    <= 24'h00_0000;
            step_r    <= 2'h0;
            len_r     <= 7'h01;
            loaded_r  <= 7'h00;
            page_r    <= 7'h00;
            last_a_r  <= 13'h0000;
            last_d_r  <= 8'h00;
            abort_r   <= 1'b0;
            ce_n_r    <= 1'b1;
            oe_n_r    <= 1'b0;
            we_n_r    <= 1'b1;
            addr_r    <= 13'h0000;
            dq_out_r  <= 8'h00;
            dq_oe_r   <= 1'b0;
            rd_data_r <= 8'h00;
            rd_vld_r  <= 1'b0;
            done_r    <= 1'b0;
            err_r     <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            tmr_r     <= tmr_nxt;
            gap_r     <= gap_nxt;
            poll_r    <= poll_nxt;
            step_r    <= step_nxt;
            len_r     <= len_nxt;
            loaded_r  <= loaded_nxt;
            page_r    <= page_nxt;
            last_a_r  <= last_a_nxt;
            last_d_r  <= last_d_nxt;
            abort_r   <= abort_nxt;
            ce_n_r    <= ce_n_nxt;
            oe_n_r    <= oe_n_nxt;
            we_n_r    <= we_n_nxt;
            addr_r    <= addr_nxt;
            dq_out_r  <= dq_out_nxt;
            dq_oe_r   <= dq_oe_nxt;
            rd_data_r <= rd_data_nxt;
            rd_vld_r  <= rd_vld_nxt;
            done_r    <= done_nxt;
            err_r     <= err_nxt;
        end
    end

    // helper: length of the current strobe low time
    logic [15:0] low_cnt_r, low_cnt_nxt;
    always_comb begin
        low_cnt_nxt = we_n_r ? 16'h0000 : low_cnt_r + 16'h0001;
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            low_cnt_r <= 16'h0000;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end

    a_oe_only_strobe: assert property (@(posedge sys_clk) disable iff (reset)
        oe_n_r |-> (!ce_n_r && !we_n_r))
        else $error("output enable high outside a strobe");
    a_read_no_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (!ce_n_r && !oe_n_r) |-> !dq_oe_r)
        else $error("host drives data while device may");
    a_write_oe_high: assert property (@(posedge sys_clk) disable iff (reset)
        !we_n_r |-> (oe_n_r && !ce_n_r && dq_oe_r))
        else $error("write strobe without oe high and data");
    a_pulse_width: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(we_n_r) |-> (low_cnt_r == WP_CYC && $past(dq_oe_r)))
        else $error("write strobe width wrong");
    a_guard_first: assert property (@(posedge sys_clk) disable iff (reset)
        ($fell(we_n_r) && step_r == 2'h0) |->
        (addr_r == `EEPG_GRD_A0 && dq_out_r == `EEPG_GRD_D0))
        else $error("write not opened by guard byte");
    a_guard_third: assert property (@(posedge sys_clk) disable iff (reset)
        ($fell(we_n_r) && step_r == 2'h2) |->
        (addr_r == `EEPG_GRD_A2 && dq_out_r == `EEPG_GRD_D2))
        else $error("third guard byte wrong");
    a_page_const: assert property (@(posedge sys_clk) disable iff (reset)
        ($fell(we_n_r) && step_r == `EEPG_GUARD_LEN) |->
        addr_r[`EEPG_PAGE_MSB:`EEPG_PAGE_LSB] == page_r)
        else $error("page bits changed during load");
    a_count_limit: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(we_n_r) |-> (loaded_r < len_r && len_r <= `EEPG_PAGE_BYTES))
        else $error("too many bytes loaded");
    a_load_window: assert property (@(posedge sys_clk) disable iff (reset)
        ($fell(we_n_r) && step_r == `EEPG_GUARD_LEN && loaded_r != 7'h00)
        |-> $past(gap_r, 2) < 16'(BLC_CYC))
        else $error("byte load later than the window");
    a_poll_bound: assert property (@(posedge sys_clk) disable iff (reset)
        (st_r == EEPG_PRD || st_r == EEPG_PGAP) |->
        poll_r <= WC_LIM + SMP_CYC + DF_CYC)
        else $error("polling ran past the program time");

endmodule : eepg_host

// file: testbench/eepg_dev.sv
// behavioural model of the guarded page-write parallel eeprom
// assumes host pins are registered on sys_clk and sampled here
`timescale 1ns/1ps
`include "eepg_cfg.svh"

module eepg_dev #(
    parameter int BLC_CYC = 200
) (
    // clock
    input  wire logic        sys_clk,
    // device pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [12:0] addr,
    input  wire logic [7:0]  dq_out,
    input  wire logic        dq_oe,
    output logic      [7:0]  dq_in,
    // model control and status
    input  wire logic [15:0] prog_cyc,
    output int               viol,
    output int               n_prog,
    output logic             prot
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  pbuf [0:63];
    logic [12:0] ga [0:2];
    logic [7:0]  gd [0:2];
    logic [63:0] pmask;
    logic [12:0] cap_a, last_a;
    logic [7:0]  last_d, hold_q;
    logic [6:0]  pg;
    logic [1:0]  gcnt;
    logic        wr_q, oe_q, loading, progm;
    int          tmr;
    wire         wr_act = !ce_n && !we_n;
    wire         rd_en  = !ce_n && !oe_n && we_n;
    wire  [7:0]  rd_val = (progm && addr == last_a) ?
                          {~last_d[7], mem[addr][6:0]} : mem[addr];

    // no pull on the bus: released lines show the inverted last byte
    assign dq_in = rd_en ? rd_val : ~hold_q;
    assign prot  = (gcnt == 2'h0) && !loading;

    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'hc3;
        ga = '{`EEPG_GRD_A0, `EEPG_GRD_A1, `EEPG_GRD_A2};
        gd = '{`EEPG_GRD_D0, `EEPG_GRD_D1, `EEPG_GRD_D2};
        {pmask, gcnt, wr_q, oe_q, loading, progm} = '0;
        {viol, n_prog, tmr, hold_q} = '0;
    end

    always @(posedge sys_clk) begin
        wr_q <= wr_act;
        oe_q <= oe_n;
        if (rd_en) hold_q <= rd_val;
        if (oe_n === 1'b1 && !wr_act) viol <= viol + 1;
        if (dq_oe === 1'b1 && rd_en) viol <= viol + 1;
        if (loading) tmr <= tmr + 1;
        // a read also closes the load period, so polling never sees old data
        if (loading && (tmr >= BLC_CYC || rd_en)) begin
            loading <= 1'b0;
            progm <= 1'b1;
            tmr <= 0;
            n_prog <= n_prog + 1;
        end
        if (progm) begin
            tmr <= tmr + 1;
            if (tmr >= prog_cyc) begin
                for (int j = 0; j < 64; j++)
                    if (pmask[j]) mem[{pg, j[5:0]}] <= pbuf[j];
                progm <= 1'b0;
                gcnt <= 2'h0;
                pmask <= '0;
            end
        end
        if (wr_act && !wr_q) cap_a <= addr;
        if (!wr_act && wr_q === 1'b1) begin
            if (oe_q !== 1'b1 || dq_oe !== 1'b1 || progm) begin
                viol <= viol + 1;
            end else if (gcnt != 2'h3) begin
                if (cap_a === ga[gcnt] && dq_out === gd[gcnt]) begin
                    gcnt <= gcnt + 2'h1;
                end else begin
                    viol <= viol + 1;
                    gcnt <= 2'h0;
                end
            end else begin
                if (loading && cap_a[12:6] !== pg) viol <= viol + 1;
                pg <= cap_a[12:6];
                pbuf[cap_a[5:0]] <= dq_out;
                pmask[cap_a[5:0]] <= 1'b1;
                loading <= 1'b1;
                tmr <= 0;
                last_a <= cap_a;
                last_d <= dq_out;
            end
        end
    end
endmodule : eepg_dev

// file: testbench/eepg_host_tb.sv
// self-checking bench for the eeprom host against the device model
// assumes shortened load window and programming counts
`timescale 1ns/1ps
`include "eepg_cfg.svh"

module eepg_host_tb;
    import eepg_pkg::*;
    localparam int BLC   = 200;
    localparam int WC    = 2000;
    localparam int LIMIT = 60000;
    logic        sys_clk, reset, cmd_valid, cmd_ready, cmd_write;
    logic [12:0] cmd_addr, addr;
    logic [6:0]  cmd_len;
    logic        wdat_valid, wdat_ready, rd_valid, wr_done, wr_err, busy;
    logic [5:0]  wdat_offs;
    logic [7:0]  wdat_byte, rd_data, dq_out, dq_in;
    logic        ce_n, oe_n, we_n, dq_oe, prot;
    logic [15:0] pcyc;
    int          viol, n_prog, mismatches, n_checks, cyc;

`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

    eepg_host #(.BLC_CYC(BLC), .WC_CYC(WC)) eepg_host_inst (
        .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .wdat_valid(wdat_valid), .wdat_ready(wdat_ready),
        .wdat_offs(wdat_offs), .wdat_byte(wdat_byte), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr_done(wr_done), .wr_err(wr_err), .busy(busy),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

    eepg_dev #(.BLC_CYC(BLC)) eepg_dev_inst (
        .sys_clk(sys_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .prog_cyc(pcyc), .viol(viol), .n_prog(n_prog), .prot(prot));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] init_val(input logic [12:0] a);
        return a[7:0] ^ 8'hc3;
    endfunction : init_val

    function automatic logic [7:0] pat(input logic [6:0] p,
                                       input logic [5:0] o);
        return {o[1:0], o} ^ {p, 1'b1};
    endfunction : pat

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            test_done();
        end
    end

    // entered and left 1 ns after a rising edge
    task automatic send_cmd(input logic w, input logic [12:0] a,
                            input logic [6:0] l);
        int k;
        cmd_write = w;
        cmd_addr = a;
        cmd_len = l;
        cmd_valid = 1'b1;
        k = 0;
        @(posedge sys_clk);
        while (cmd_ready !== 1'b1 && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        #1;
        cmd_valid = 1'b0;
        `CHK(k < 200, 1'b1)
    endtask : send_cmd

    task automatic do_read(input logic [12:0] a, input logic [7:0] exp);
        int k;
        send_cmd(1'b0, a, 7'h01);
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (rd_valid !== 1'b1 && k < 60);
        `CHK(k >= 34 && k <= 35, 1'b1)
        `CHK(rd_data, exp)
    endtask : do_read

    // offsets go downwards from the top of the page
    task automatic do_write(input logic [6:0] p, input int n_send,
                            input logic [6:0] n_len, input logic [15:0] pc,
                            input logic exp_err);
        int k;
        int t0;
        int np0;
        pcyc = pc;
        np0 = n_prog;
        send_cmd(1'b1, {p, 6'h00}, n_len);
        wdat_valid = 1'b1;
        for (int j = 0; j < n_send; j++) begin
            wdat_offs = 6'h3f - j[5:0];
            wdat_byte = pat(p, wdat_offs);
            k = 0;
            @(posedge sys_clk);
            while (wdat_ready !== 1'b1 && k < 500) begin
                @(posedge sys_clk);
                k++;
            end
            #1;
        end
        wdat_valid = 1'b0;
        t0 = cyc;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (wr_done !== 1'b1 && k < 6000);
        `CHK(wr_done, 1'b1)
        `CHK(wr_err, exp_err)
        `CHK(n_prog, np0 + 1)
        if (!exp_err) `CHK(cyc - t0 >= pc, 1'b1)
        // a slow device is still programming when the host gives up
        if (pc > WC) begin
            repeat (400) @(posedge sys_clk);
            #1;
        end
        `CHK(prot, 1'b1)
        for (int j = 0; j < n_send; j++)
            do_read({p, 6'h3f - j[5:0]}, pat(p, 6'h3f - j[5:0]));
    endtask : do_write

    initial begin
        {mismatches, n_checks, cyc} = '0;
        {cmd_valid, cmd_write, wdat_valid} = '0;
        reset = 1'b1;
        cmd_addr = 13'h0000;
        cmd_len = 7'h01;
        wdat_offs = 6'h00;
        wdat_byte = 8'h00;
        pcyc = 16'h0258;
        repeat (6) @(posedge sys_clk);
        #1;
        `CHK({ce_n, we_n, oe_n, dq_oe}, 4'hc)
        `CHK(cmd_ready, 1'b1)
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        do_read(13'h0000, init_val(13'h0000));
        do_read(13'h1fff, init_val(13'h1fff));
        do_write(7'h00, 1, 7'h01, 16'h0258, 1'b0);
        // a zero length asks for a single byte
        do_write(7'h10, 1, 7'h00, 16'h0258, 1'b0);
        do_write(7'h7f, 64, 7'h40, 16'h0708, 1'b0);
        // two of four bytes, then the load window runs out
        do_write(7'h2a, 2, 7'h04, 16'h0258, 1'b1);
        // device slower than the poll limit
        do_write(7'h33, 2, 7'h02, 16'h08fc, 1'b1);
        do_read(`EEPG_GRD_A0, init_val(`EEPG_GRD_A0));
        do_read(`EEPG_GRD_A1, init_val(`EEPG_GRD_A1));
        `CHK(viol, 0)
        test_done();
    end
endmodule : eepg_host_tb
